//--- hdl/pdr_profile_regs.sv
// register bank holding one loop profile for the third reference input
// What this block does
// R1: the two priority bits give the input's switchover rank 0 to 3, 0 highest.
// R2: the loop may lock to this input only while the enable bit is 1.
// R3: the 17-bit bandwidth factor in 0.1 Hz is low byte, mid byte, top bit.
// R4: software keeps bandwidth below phase detector frequency over 20.
// R5: software avoids bandwidth under 50 Hz with a crystal system clock.
// R6: filter-select bit 1 picks normal 70 degree or high phase margin.
// R7: software should pick high phase margin, also above 2 kHz.
// R8: the 18-bit integer divider, value minus one, spans three registers.
// R9: the 24-bit numerator spans three bytes, low byte first, reset zero.
// R10: the 24-bit modulus spans three bytes, low byte first, reset zero.
// R11: bandwidth, divider and reserved bits all reset to zero.
// R12: software never runs the loop with a zero bandwidth factor.
// R13: while tracking this input the profile is applied, ratio n+1+num/mod.
//
// Design decision made here: the Wishbone slave port.
module pdr_profile_regs
  import pdr_pkg::*;
(
  // clock, reset and enable
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [ADR_W-1:0] WB_ADR_I,
  input wire logic [DAT_W-1:0] WB_DAT_I,
  output logic [DAT_W-1:0] WB_DAT_O,
  output logic WB_ACK_O,
  // loop status from the digital loop
  input wire logic TRACKING_I,
  // switchover selection
  output logic [PRIO_W-1:0] REF_RANK_O,
  output logic [RANK_N-1:0] RANK_ONEHOT_O,
  output logic LOCK_ALLOW_O,
  // profile applied to the loop, and zero flag of the stored bandwidth
  output logic PROFILE_ACTIVE_O,
  output logic [BW_W-1:0] LOOP_BW_O,
  output logic HIGH_PM_O,
  output logic [RATIO_W-1:0] FB_INT_RATIO_O,
  output logic [FRAC_W-1:0] FB_NUM_O,
  output logic [FRAC_W-1:0] FB_MOD_O,
  output logic BW_ZERO_O
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [PRIO_W-1:0] prio;
    logic en;
    logic [BW_W-1:0] bw;
    logic fsel;
    logic [NDIV_W-1:0] ndiv;
    logic [FRAC_W-1:0] num;
    logic [FRAC_W-1:0] modu;
    logic [RANK_N-1:0] onehot;
    logic active;
    logic [BW_W-1:0] a_bw;
    logic a_fsel;
    logic [RATIO_W-1:0] a_ratio;
    logic [FRAC_W-1:0] a_num;
    logic [FRAC_W-1:0] a_mod;
    logic bw_zero;
  } pdr_top_s;

  pdr_top_s s_r;
  pdr_top_s s_nxt;
  logic [DAT_W-1:0] wb_dat;
  logic wb_ack;

  pdr_link_if lnk ();

  // ****************************************************************
  // submodules
  // ****************************************************************
  pdr_wb_slave u_bus (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .wb_cyc_i(WB_CYC_I),
    .wb_stb_i(WB_STB_I),
    .wb_we_i(WB_WE_I),
    .wb_sel_i(WB_SEL_I),
    .wb_adr_i(WB_ADR_I),
    .wb_dat_i(WB_DAT_I),
    .wb_dat_o(wb_dat),
    .wb_ack_o(wb_ack),
    .lnk(lnk.bus)
  );

  pdr_ratio u_ratio (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .lnk(lnk.calc)
  );

  assign lnk.ndiv = s_r.ndiv;
  assign lnk.bw = s_r.bw;

  // ****************************************************************
  // register read-back, reserved bits read zero
  // ****************************************************************
  always_comb begin
    lnk.rdata = RSVD_BYTE;
    case (lnk.idx)
      IDX_PRIO_EN: begin
        lnk.rdata[PRIO_LSB +: PRIO_W] = s_r.prio;
        lnk.rdata[EN_BIT] = s_r.en;
      end
      IDX_BW_LOW: lnk.rdata = s_r.bw[7:0];
      IDX_BW_MID: lnk.rdata = s_r.bw[15:8];
      IDX_FSEL_BW_TOP: begin
        lnk.rdata[FSEL_BIT] = s_r.fsel;
        lnk.rdata[BW_TOP_BIT] = s_r.bw[16];
      end
      IDX_NDIV_LOW: lnk.rdata = s_r.ndiv[7:0];
      IDX_NDIV_MID: lnk.rdata = s_r.ndiv[15:8];
      IDX_NDIV_TOP: lnk.rdata[NDIV_TOP_W-1:0] = s_r.ndiv[17:16];
      IDX_NUM_LOW: lnk.rdata = s_r.num[7:0];
      IDX_NUM_MID: lnk.rdata = s_r.num[15:8];
      IDX_NUM_HIGH: lnk.rdata = s_r.num[23:16];
      IDX_MOD_LOW: lnk.rdata = s_r.modu[7:0];
      IDX_MOD_MID: lnk.rdata = s_r.modu[15:8];
      IDX_MOD_HIGH: lnk.rdata = s_r.modu[23:16];
      default: lnk.rdata = RSVD_BYTE;
    endcase
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_nxt = s_r;
    if (lnk.wr) begin
      case (lnk.idx)
        IDX_PRIO_EN: begin
          s_nxt.prio = lnk.wdata[PRIO_LSB +: PRIO_W]; // see R1
          s_nxt.en = lnk.wdata[EN_BIT]; // see R2
        end
        IDX_BW_LOW: s_nxt.bw[7:0] = lnk.wdata; // see R3
        IDX_BW_MID: s_nxt.bw[15:8] = lnk.wdata; // see R3
        IDX_FSEL_BW_TOP: begin
          s_nxt.fsel = lnk.wdata[FSEL_BIT]; // see R6
          s_nxt.bw[16] = lnk.wdata[BW_TOP_BIT]; // see R3
        end
        IDX_NDIV_LOW: s_nxt.ndiv[7:0] = lnk.wdata; // see R8
        IDX_NDIV_MID: s_nxt.ndiv[15:8] = lnk.wdata; // see R8
        IDX_NDIV_TOP: begin
          s_nxt.ndiv[17:16] = lnk.wdata[NDIV_TOP_W-1:0]; // see R8
        end
        IDX_NUM_LOW: s_nxt.num[7:0] = lnk.wdata; // see R9
        IDX_NUM_MID: s_nxt.num[15:8] = lnk.wdata; // see R9
        IDX_NUM_HIGH: s_nxt.num[23:16] = lnk.wdata; // see R9
        IDX_MOD_LOW: s_nxt.modu[7:0] = lnk.wdata; // see R10
        IDX_MOD_MID: s_nxt.modu[15:8] = lnk.wdata; // see R10
        IDX_MOD_HIGH: s_nxt.modu[23:16] = lnk.wdata; // see R10
        default: s_nxt.en = s_r.en;
      endcase
    end
    // rank decode, bit n set for rank n
    s_nxt.onehot = RANK_OH_RST << s_nxt.prio; // see R1
    // the loop may only use this input while enabled
    s_nxt.active = TRACKING_I & s_nxt.en; // see R2
    // apply the stored profile while the loop tracks this input
    if (TRACKING_I) begin
      s_nxt.a_bw = s_r.bw; // see R13
      s_nxt.a_fsel = s_r.fsel; // see R6
      s_nxt.a_ratio = lnk.int_ratio; // see R13
      s_nxt.a_num = s_r.num; // see R13
      s_nxt.a_mod = s_r.modu; // see R13
    end
    s_nxt.bw_zero = lnk.bw_zero;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s_r.prio <= PRIO_RST; // see R1
      s_r.en <= EN_RST; // see R2
      s_r.bw <= BW_RST; // see R11
      s_r.fsel <= FSEL_RST; // see R6
      s_r.ndiv <= NDIV_RST; // see R11
      s_r.num <= NUM_RST; // see R9
      s_r.modu <= MOD_RST; // see R10
      s_r.onehot <= RANK_OH_RST;
      s_r.active <= 1'b0;
      s_r.a_bw <= BW_RST;
      s_r.a_fsel <= FSEL_RST;
      s_r.a_ratio <= RATIO_RST;
      s_r.a_num <= NUM_RST;
      s_r.a_mod <= MOD_RST;
      s_r.bw_zero <= 1'b1;
    end else if (CE_I) begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign WB_DAT_O = wb_dat;
  assign WB_ACK_O = wb_ack;
  assign REF_RANK_O = s_r.prio;
  assign RANK_ONEHOT_O = s_r.onehot;
  assign LOCK_ALLOW_O = s_r.en;
  assign PROFILE_ACTIVE_O = s_r.active;
  assign LOOP_BW_O = s_r.a_bw;
  assign HIGH_PM_O = s_r.a_fsel;
  assign FB_INT_RATIO_O = s_r.a_ratio;
  assign FB_NUM_O = s_r.a_num;
  assign FB_MOD_O = s_r.a_mod;
  assign BW_ZERO_O = s_r.bw_zero;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_N_I);

  a_rank_write: assert property ( // see R1
    (lnk.wr && CE_I && lnk.idx == IDX_PRIO_EN)
    |=> (REF_RANK_O == $past(lnk.wdata[2:1])))
    else $error("rank field not taken from write data");

  a_rank_onehot: assert property ( // see R1
    CE_I |=> (RANK_ONEHOT_O == (RANK_OH_RST << REF_RANK_O)))
    else $error("rank decode does not match rank field");

  a_lock_gate: assert property ( // see R2
    PROFILE_ACTIVE_O |-> LOCK_ALLOW_O)
    else $error("profile active with input disabled");

  a_active_track: assert property ( // see R2
    (CE_I && !TRACKING_I) |=> !PROFILE_ACTIVE_O)
    else $error("profile active while not tracking");

  a_bw_bytes: assert property ( // see R3
    (lnk.wr && CE_I && lnk.idx == IDX_BW_MID)
    |=> (s_r.bw[15:8] == $past(lnk.wdata)) && $stable(s_r.bw[7:0]))
    else $error("bandwidth middle byte misplaced");

  a_bw_top_bit: assert property ( // see R3
    (lnk.wr && CE_I && lnk.idx == IDX_FSEL_BW_TOP)
    |=> (s_r.bw[16] == $past(lnk.wdata[0]))
        && (s_r.fsel == $past(lnk.wdata[1])))
    else $error("bandwidth bit 16 or filter select misplaced");

  a_filter_apply: assert property ( // see R6
    (CE_I && TRACKING_I) ##1 (CE_I && TRACKING_I)
    |=> (HIGH_PM_O == $past(s_r.fsel)))
    else $error("filter selection not applied while tracking");

  a_hold_untracked: assert property ( // see R13
    (CE_I && !TRACKING_I) |=> $stable(LOOP_BW_O) && $stable(FB_NUM_O))
    else $error("applied profile changed while not tracking");

  a_ndiv_top: assert property ( // see R8
    (lnk.wr && CE_I && lnk.idx == IDX_NDIV_TOP)
    |=> (s_r.ndiv[17:16] == $past(lnk.wdata[1:0]))
        && $stable(s_r.ndiv[15:0]))
    else $error("integer divider top bits misplaced");

  a_num_high: assert property ( // see R9
    (lnk.wr && CE_I && lnk.idx == IDX_NUM_HIGH)
    |=> (FRAC_W'(s_r.num >> 16) == FRAC_W'($past(lnk.wdata))))
    else $error("numerator high byte misplaced");

  a_mod_low: assert property ( // see R10
    (lnk.wr && CE_I && lnk.idx == IDX_MOD_LOW)
    |=> (s_r.modu[7:0] == $past(lnk.wdata)) && $stable(s_r.modu[23:8]))
    else $error("modulus low byte misplaced");

  a_reserved_zero: assert property ( // see R11
    (lnk.idx == IDX_PRIO_EN) |-> (lnk.rdata[7:3] == 5'h00))
    else $error("reserved priority bits read nonzero");

  a_ratio_apply: assert property ( // see R13
    (CE_I && TRACKING_I) |=> (FB_INT_RATIO_O == $past(lnk.int_ratio)))
    else $error("integer ratio not applied while tracking");

  a_en_write: assert property ( // see R2
    (lnk.wr && CE_I && lnk.idx == IDX_PRIO_EN)
    |=> (LOCK_ALLOW_O == $past(lnk.wdata[EN_BIT])))
    else $error("enable bit not taken from write data");

  a_active_set: assert property ( // see R2
    (CE_I && TRACKING_I) |=> (PROFILE_ACTIVE_O == LOCK_ALLOW_O))
    else $error("tracking an enabled input left profile inactive");

  a_bw_low: assert property ( // see R3
    (lnk.wr && CE_I && lnk.idx == IDX_BW_LOW)
    |=> (s_r.bw[7:0] == $past(lnk.wdata)) && $stable(s_r.bw[16:8]))
    else $error("bandwidth low byte misplaced");

  a_ndiv_low: assert property ( // see R8
    (lnk.wr && CE_I && lnk.idx == IDX_NDIV_LOW)
    |=> (s_r.ndiv[7:0] == $past(lnk.wdata)) && $stable(s_r.ndiv[17:8]))
    else $error("integer divider low byte misplaced");

  a_ndiv_mid: assert property ( // see R8
    (lnk.wr && CE_I && lnk.idx == IDX_NDIV_MID)
    |=> (s_r.ndiv[15:8] == $past(lnk.wdata)) && $stable(s_r.ndiv[7:0]))
    else $error("integer divider middle byte misplaced");

  a_num_low: assert property ( // see R9
    (lnk.wr && CE_I && lnk.idx == IDX_NUM_LOW)
    |=> (s_r.num[7:0] == $past(lnk.wdata)) && $stable(s_r.num[23:8]))
    else $error("numerator low byte misplaced");

  a_num_mid: assert property ( // see R9
    (lnk.wr && CE_I && lnk.idx == IDX_NUM_MID)
    |=> (s_r.num[15:8] == $past(lnk.wdata)) && $stable(s_r.num[7:0]))
    else $error("numerator middle byte misplaced");

  a_mod_mid: assert property ( // see R10
    (lnk.wr && CE_I && lnk.idx == IDX_MOD_MID)
    |=> (s_r.modu[15:8] == $past(lnk.wdata)) && $stable(s_r.modu[7:0]))
    else $error("modulus middle byte misplaced");

  a_mod_high: assert property ( // see R10
    (lnk.wr && CE_I && lnk.idx == IDX_MOD_HIGH)
    |=> (s_r.modu[23:16] == $past(lnk.wdata)) && $stable(s_r.modu[15:0]))
    else $error("modulus high byte misplaced");

  a_frac_apply: assert property ( // see R13
    (CE_I && TRACKING_I)
    |=> (FB_NUM_O == $past(s_r.num)) && (FB_MOD_O == $past(s_r.modu)))
    else $error("fractional settings not applied while tracking");

  a_bw_apply: assert property ( // see R13
    (CE_I && TRACKING_I) |=> (LOOP_BW_O == $past(s_r.bw)))
    else $error("bandwidth not applied while tracking");

  a_hold_rest: assert property ( // see R13
    (CE_I && !TRACKING_I)
    |=> $stable(HIGH_PM_O) && $stable(FB_INT_RATIO_O) && $stable(FB_MOD_O))
    else $error("applied divider or filter changed while not tracking");

  a_zero_flag: assert property ( // see R12
    (CE_I ##1 CE_I) |=> (BW_ZERO_O == ($past(s_r.bw, 2) == BW_RST)))
    else $error("zero bandwidth flag out of step");

  a_frozen: assert property (
    !CE_I |=> $stable(s_r) && $stable(WB_ACK_O))
    else $error("state changed while clock enable low");

endmodule

//--- hdl/pdr_pkg.sv
// constants of the reference-profile register bank
package pdr_pkg;

  // ****************************************************************
  // bus geometry
  // ****************************************************************
  localparam int IDX_W = 11;
  localparam int ADR_W = IDX_W + 2;
  localparam int DAT_W = 32;
  localparam int BYTE_W = 8;

  // ****************************************************************
  // register indices, byte address is four times the index
  // ****************************************************************
  localparam logic [IDX_W-1:0] IDX_PRIO_EN = 11'h45a;
  localparam logic [IDX_W-1:0] IDX_BW_LOW = 11'h45b;
  localparam logic [IDX_W-1:0] IDX_BW_MID = 11'h45c;
  localparam logic [IDX_W-1:0] IDX_FSEL_BW_TOP = 11'h45d;
  localparam logic [IDX_W-1:0] IDX_NDIV_LOW = 11'h45e;
  localparam logic [IDX_W-1:0] IDX_NDIV_MID = 11'h45f;
  localparam logic [IDX_W-1:0] IDX_NDIV_TOP = 11'h460;
  localparam logic [IDX_W-1:0] IDX_NUM_LOW = 11'h461;
  localparam logic [IDX_W-1:0] IDX_NUM_MID = 11'h462;
  localparam logic [IDX_W-1:0] IDX_NUM_HIGH = 11'h463;
  localparam logic [IDX_W-1:0] IDX_MOD_LOW = 11'h464;
  localparam logic [IDX_W-1:0] IDX_MOD_MID = 11'h465;
  localparam logic [IDX_W-1:0] IDX_MOD_HIGH = 11'h466;

  // ****************************************************************
  // field positions and widths
  // ****************************************************************
  localparam int PRIO_LSB = 1;
  localparam int PRIO_W = 2;
  localparam int EN_BIT = 0;
  localparam int FSEL_BIT = 1;
  localparam int BW_TOP_BIT = 0;
  localparam int BW_W = 17;
  localparam int NDIV_W = 18;
  localparam int NDIV_TOP_W = 2;
  localparam int FRAC_W = 24;
  localparam int RATIO_W = NDIV_W + 1;
  localparam int RANK_N = 4;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [PRIO_W-1:0] PRIO_RST = 2'h0;
  localparam logic EN_RST = 1'b0;
  localparam logic [BW_W-1:0] BW_RST = 17'h00000;
  localparam logic FSEL_RST = 1'b0;
  localparam logic [NDIV_W-1:0] NDIV_RST = 18'h00000;
  localparam logic [FRAC_W-1:0] NUM_RST = 24'h000000;
  localparam logic [FRAC_W-1:0] MOD_RST = 24'h000000;
  localparam logic [RANK_N-1:0] RANK_OH_RST = 4'h1;
  localparam logic [RATIO_W-1:0] RATIO_RST = 19'h00001;
  localparam logic [BYTE_W-1:0] RSVD_BYTE = 8'h00;

endpackage

//--- hdl/pdr_link_if.sv
// link between the bus slave, the ratio unit and the register bank
interface pdr_link_if;
  import pdr_pkg::*;

  logic wr;
  logic [IDX_W-1:0] idx;
  logic [BYTE_W-1:0] wdata;
  logic [BYTE_W-1:0] rdata;
  logic [NDIV_W-1:0] ndiv;
  logic [BW_W-1:0] bw;
  logic [RATIO_W-1:0] int_ratio;
  logic bw_zero;

  modport bus (output wr, output idx, output wdata, input rdata);
  modport regs (input wr, input idx, input wdata, output rdata,
                output ndiv, output bw, input int_ratio, input bw_zero);
  modport calc (input ndiv, input bw, output int_ratio, output bw_zero);
endinterface

//--- hdl/pdr_wb_slave.sv
// classic wishbone slave front end of the register bank
module pdr_wb_slave
  import pdr_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  output logic [DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // register side
  pdr_link_if.bus lnk
);

  typedef struct packed {
    logic ack;
    logic [DAT_W-1:0] dat;
  } pdr_wb_s;

  pdr_wb_s s_r;
  pdr_wb_s s_nxt;
  logic req;

  assign req = wb_cyc_i & wb_stb_i;
  assign lnk.idx = wb_adr_i[ADR_W-1:2];
  assign lnk.wdata = wb_dat_i[BYTE_W-1:0];
  // write commits on the edge where the master samples ack
  assign lnk.wr = ce_i & req & wb_we_i & wb_sel_i[0] & s_r.ack;

  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = req & ~s_r.ack;
    if (req & ~s_r.ack) begin
      s_nxt.dat = {{(DAT_W-BYTE_W){1'b0}}, lnk.rdata};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  assign wb_ack_o = s_r.ack;
  assign wb_dat_o = s_r.dat;

  a_ack_next: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && req && !wb_ack_o) |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && wb_ack_o) |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
endmodule

//--- hdl/pdr_ratio.sv
// effective integer ratio and zero-bandwidth flag
module pdr_ratio
  import pdr_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // settings in, ratio out
  pdr_link_if.calc lnk
);

  typedef struct packed {
    logic [RATIO_W-1:0] int_ratio;
    logic bw_zero;
  } pdr_ratio_s;

  pdr_ratio_s s_r;
  pdr_ratio_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    // divider is programmed as value minus one
    s_nxt.int_ratio = {1'b0, lnk.ndiv} + RATIO_W'(1); // see R13
    s_nxt.bw_zero = (lnk.bw == BW_RST);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r.int_ratio <= RATIO_RST;
      s_r.bw_zero <= 1'b1;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  assign lnk.int_ratio = s_r.int_ratio;
  assign lnk.bw_zero = s_r.bw_zero;

  a_ratio_plus_one: assert property ( // see R13
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i |=> (lnk.int_ratio == {1'b0, $past(lnk.ndiv)} + RATIO_W'(1)))
    else $error("integer ratio is not divider plus one");
endmodule

//--- tb/pdr_profile_regs_bench.sv
// self-checking bench of the reference-profile register bank
`define CHK(got, exp, msg) begin compares++; if ((got) !== (exp)) begin \
  n_fail++; $display("mismatch %0t %s", $time, msg); end end

module pdr_profile_regs_bench
  import pdr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************************************
  // signals
  // ****************************************************************
  logic clk, rst_n, ce, cyc, stb, we, trk;
  logic [3:0] sel;
  logic [ADR_W-1:0] adr;
  logic [DAT_W-1:0] dat_w, dat_r, rd;
  logic ack, lock_allow, active, high_pm, bw_zero;
  logic [PRIO_W-1:0] rank;
  logic [RANK_N-1:0] onehot;
  logic [BW_W-1:0] loop_bw;
  logic [RATIO_W-1:0] int_ratio;
  logic [FRAC_W-1:0] num, modu;
  int n_fail = 0;
  int compares = 0;
  int lat_exp = 2;

  pdr_profile_regs dut (
    .CLOCK_I(clk), .RST_N_I(rst_n), .CE_I(ce),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_SEL_I(sel),
    .WB_ADR_I(adr), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
    .TRACKING_I(trk), .REF_RANK_O(rank), .RANK_ONEHOT_O(onehot),
    .LOCK_ALLOW_O(lock_allow), .PROFILE_ACTIVE_O(active),
    .LOOP_BW_O(loop_bw), .HIGH_PM_O(high_pm),
    .FB_INT_RATIO_O(int_ratio), .FB_NUM_O(num), .FB_MOD_O(modu),
    .BW_ZERO_O(bw_zero)
  );

  initial clk = 1'b0;
  always #25 clk = ~clk;

  // ****************************************************************
  // bus tasks
  // ****************************************************************
  task automatic xfer(input logic w, input logic [IDX_W-1:0] idx,
                      input logic [7:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= s;
    adr <= {idx, 2'b00};
    dat_w <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    `CHK(n, lat_exp, "bus answer latency")
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d, 4'hf);
  endtask

  task automatic chk_reg(input logic [IDX_W-1:0] idx,
                         input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00, 4'hf);
    `CHK(rd, {24'h000000, exp}, "register read")
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic print_verdict;
    if (n_fail == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    print_verdict();
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    sel = 4'h0;
    adr = '0;
    dat_w = '0;
    trk = 1'b0;
    settle(8);
    `CHK(onehot, 4'h1, "reset rank onehot")
    `CHK(int_ratio, 19'h00001, "reset ratio")
    `CHK(bw_zero, 1'b1, "reset bw zero flag")
    `CHK(lock_allow, 1'b0, "reset enable")
    `CHK(loop_bw, 17'h00000, "reset bandwidth")
    @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 13; i++) begin
      chk_reg(IDX_PRIO_EN + 11'(i), 8'h00);
    end
    // every rank, reserved bits written high
    for (int r = 0; r < 4; r++) begin
      wr(IDX_PRIO_EN, {5'h1f, 2'(r), r[0]});
      chk_reg(IDX_PRIO_EN, {5'h00, 2'(r), r[0]});
      settle(2);
      `CHK(rank, 2'(r), "rank")
      `CHK(onehot, 4'h1 << r, "rank onehot")
      `CHK(lock_allow, r[0], "enable")
      `CHK(active, 1'b0, "active without tracking")
    end
    // nonzero bandwidth well below the detector limit
    @(posedge clk);
    trk <= 1'b1;
    wr(IDX_BW_LOW, 8'h34);
    wr(IDX_BW_MID, 8'h12);
    wr(IDX_FSEL_BW_TOP, 8'hff);
    chk_reg(IDX_FSEL_BW_TOP, 8'h03);
    settle(3);
    `CHK(loop_bw, 17'h11234, "bandwidth")
    `CHK(high_pm, 1'b1, "high margin")
    `CHK(bw_zero, 1'b0, "bw zero flag")
    `CHK(active, 1'b1, "active")
    wr(IDX_FSEL_BW_TOP, 8'h01);
    settle(3);
    `CHK(high_pm, 1'b0, "normal margin")
    `CHK(loop_bw, 17'h11234, "bandwidth top bit")
    // integer divider, mid value then the largest
    wr(IDX_NDIV_LOW, 8'ha5);
    wr(IDX_NDIV_MID, 8'h5a);
    wr(IDX_NDIV_TOP, 8'hff);
    chk_reg(IDX_NDIV_TOP, 8'h03);
    chk_reg(IDX_NDIV_MID, 8'h5a);
    settle(3);
    `CHK(int_ratio, 19'h35aa6, "ratio")
    wr(IDX_NDIV_LOW, 8'hff);
    wr(IDX_NDIV_MID, 8'hff);
    settle(3);
    `CHK(int_ratio, 19'h40000, "largest ratio")
    // numerator and modulus bytes
    for (int i = 0; i < 6; i++) begin
      wr(IDX_NUM_LOW + 11'(i), 8'(8'h11 * (i + 1)));
      chk_reg(IDX_NUM_LOW + 11'(i), 8'(8'h11 * (i + 1)));
    end
    settle(2);
    `CHK(num, 24'h332211, "numerator")
    `CHK(modu, 24'h665544, "modulus")
    // not tracking: applied profile holds
    @(posedge clk);
    trk <= 1'b0;
    wr(IDX_BW_LOW, 8'h00);
    wr(IDX_BW_MID, 8'h00);
    wr(IDX_FSEL_BW_TOP, 8'h02);
    wr(IDX_PRIO_EN, 8'h00);
    settle(3);
    `CHK(loop_bw, 17'h11234, "held bandwidth")
    `CHK(high_pm, 1'b0, "held margin")
    `CHK(bw_zero, 1'b1, "bw zero flag")
    `CHK(lock_allow, 1'b0, "disabled")
    `CHK(active, 1'b0, "inactive")
    // unmapped place and unselected byte lane
    wr(11'h467, 8'hff);
    chk_reg(11'h467, 8'h00);
    xfer(1'b1, IDX_NUM_LOW, 8'hee, 4'he);
    chk_reg(IDX_NUM_LOW, 8'h11);
    // clock enable low stalls the answer
    @(posedge clk);
    ce <= 1'b0;
    // four frozen edges push the answer out by three cycles
    lat_exp = 5;
    fork
      wr(IDX_MOD_LOW, 8'h99);
      begin
        repeat (4) begin
          @(posedge clk);
          `CHK(ack, 1'b0, "answer while frozen")
        end
        ce <= 1'b1;
      end
    join
    lat_exp = 2;
    chk_reg(IDX_MOD_LOW, 8'h99);
    // second reset in mid-run
    @(posedge clk);
    rst_n <= 1'b0;
    settle(2);
    `CHK(int_ratio, 19'h00001, "ratio after reset")
    @(posedge clk);
    rst_n <= 1'b1;
    chk_reg(IDX_NUM_LOW, 8'h00);
    chk_reg(IDX_NDIV_TOP, 8'h00);
    settle(2);
    print_verdict();
  end
endmodule
